/* File: logic/fmer_diag_mem.sv */
/*
 * fmer_diag_mem: diagnostic buffer storage, one write port, registered read.
 * Assumes the writer wraps its own address; read data lag raddr by one edge.
 */
`timescale 1ns/1ps
module fmer_diag_mem #(
   parameter int W     = 96,
   parameter int DEPTH = 16,
   parameter int AW    = 4
) (
   input  wire logic          clk_i,
   input  wire logic          we_i,
   input  wire logic [AW-1:0] waddr_i,
   input  wire logic [W-1:0]  wdata_i,
   input  wire logic [AW-1:0] raddr_i,
   output logic      [W-1:0]  rdata_o
);
   logic [W-1:0] mem [DEPTH];

   always_ff @(posedge clk_i) begin
      if (we_i) begin
         mem[waddr_i] <= wdata_i;
      end
   end

   // no reset: contents are only meaningful once counted as written
   always_ff @(posedge clk_i) begin
      rdata_o <= mem[raddr_i];
   end
endmodule

/* File: logic/fmer_pkg.sv */
/*
 * fmer_pkg: constants and types of the fieldbus master event reporter.
 * Assumes one system clock; register offsets are APB byte addresses.
 */
package fmer_pkg;
   typedef logic [7:0]  fmer_byte_t;
   typedef logic [15:0] fmer_word_t;
   typedef logic [31:0] fmer_data_t;
   typedef logic [7:0]  fmer_addr_t;

   // apb register byte addresses
   localparam fmer_addr_t ADDR_CTRL   = 8'h00;
   localparam fmer_addr_t ADDR_PRIO   = 8'h04;
   localparam fmer_addr_t ADDR_MADDR  = 8'h08;
   localparam fmer_addr_t ADDR_IOADDR = 8'h0C;
   localparam fmer_addr_t ADDR_SYSID  = 8'h10;
   localparam fmer_addr_t ADDR_PEN    = 8'h14;
   localparam fmer_addr_t ADDR_TOPO   = 8'h18;
   localparam fmer_addr_t ADDR_SYNC   = 8'h1C;
   localparam fmer_addr_t ADDR_DIDX   = 8'h20;
   localparam fmer_addr_t ADDR_DW0    = 8'h24;
   localparam fmer_addr_t ADDR_DW1    = 8'h28;
   localparam fmer_addr_t ADDR_DW2    = 8'h2C;
   localparam fmer_addr_t ADDR_SNAP0  = 8'h30;
   localparam fmer_addr_t ADDR_SNAP1  = 8'h34;
   localparam fmer_addr_t ADDR_SNAP2  = 8'h38;

   // event codes, classes, fault identifiers, handler numbers
   localparam fmer_word_t CODE_TOPO   = 16'h8003;
   localparam fmer_word_t CODE_SYNC   = 16'h8005;
   localparam fmer_word_t CODE_CYC    = 16'h8006;
   localparam fmer_word_t CODE_RX     = 16'h8007;
   localparam fmer_byte_t CLS_ARRIVE  = 8'hEC;
   localparam fmer_byte_t CLS_DEPART  = 8'hED;
   localparam fmer_byte_t FLT_TOPO    = 8'h30;
   localparam fmer_byte_t FLT_CYC     = 8'h40;
   localparam fmer_byte_t FLT_SYNC    = 8'h50;
   localparam fmer_byte_t FLT_RX      = 8'h80;
   localparam fmer_byte_t HNO_RACK    = 8'h56;  // handler 86
   localparam fmer_byte_t HNO_DIAG    = 8'h52;  // handler 82
   localparam fmer_word_t WORD_ZERO   = 16'h0000;

   // penalty monitor
   localparam logic [3:0] PEN_INC     = 4'h3;
   localparam logic [3:0] PEN_DEC     = 4'h1;
   localparam logic [3:0] PEN_MAX     = 4'h9;
   localparam logic [3:0] PEN_MIN     = 4'h0;
   localparam int         MON_CYC     = 0;
   localparam int         MON_RX      = 1;

   // receive-timeout third info word
   localparam fmer_byte_t SYSID_BIAS  = 8'h64;  // 100
   localparam int         RX_ID_LSB   = 11;
   localparam int         RX_FLAG_BIT = 15;

   // event sources, lower index served first
   localparam int         NSRC        = 6;
   typedef enum logic [2:0] {
      SRC_TOPO   = 3'b000,
      SRC_SYNC   = 3'b001,
      SRC_CYC_NG = 3'b010,
      SRC_CYC_OK = 3'b011,
      SRC_RX_NG  = 3'b100,
      SRC_RX_OK  = 3'b101
   } fmer_src_t;

   localparam int         ENTRY_W     = 96;
   localparam int         CTRL_DIAG_PRESENT = 0;
endpackage

/* File: logic/fmer_top.sv */
/*
 * fmer_top: event reporter of a fieldbus master toward the host cpu.
 * Assumes all inputs synchronous to clk_i and an apb master on the bus.
 */
`timescale 1ns/1ps
module fmer_top #(
   parameter int NSLAVE     = 8,
   parameter int DIAG_DEPTH = 16
) (
   input  wire logic               clk_i,
   input  wire logic               rstn_i,
   input  wire logic               psel_i,
   input  wire logic               penable_i,
   input  wire logic               pwrite_i,
   input  wire fmer_pkg::fmer_addr_t paddr_i,
   input  wire fmer_pkg::fmer_data_t pwdata_i,
   output fmer_pkg::fmer_data_t    prdata_o,
   output logic                    pready_o,
   output logic                    pslverr_o,
   input  wire logic               topo_match_i,
   input  wire logic [NSLAVE-1:0]  cfg_topo_i,
   input  wire logic [NSLAVE-1:0]  act_topo_i,
   input  wire logic               master_sync_i,
   input  wire logic [NSLAVE-1:0]  slave_sync_i,
   input  wire logic               cyc_tick_i,
   input  wire logic               cyc_viol_i,
   input  wire logic               rx_tick_i,
   input  wire logic               rx_timeout_i,
   output logic                    evt_valid_o,
   output logic                    evt_invoke_o,
   output fmer_pkg::fmer_word_t    evt_code_o,
   output fmer_pkg::fmer_byte_t    evt_class_o,
   output fmer_pkg::fmer_byte_t    evt_fault_o,
   output fmer_pkg::fmer_byte_t    evt_prio_o,
   output fmer_pkg::fmer_byte_t    evt_handler_o,
   output fmer_pkg::fmer_word_t    evt_info1_o,
   output fmer_pkg::fmer_word_t    evt_info2_o,
   output fmer_pkg::fmer_word_t    evt_info3_o
);
   import fmer_pkg::*;

   localparam int AW = $clog2(DIAG_DEPTH);
   localparam int CW = AW + 1;

   // software registers
   fmer_data_t          ctrl_reg;
   fmer_word_t          prio_reg;
   fmer_word_t          maddr_reg;
   fmer_word_t          ioaddr_reg;
   fmer_byte_t          sysid_reg;
   logic [AW-1:0]       didx_reg;
   // apb answer
   logic                pready_reg;
   logic                pslverr_reg;
   fmer_data_t          prdata_reg;
   fmer_data_t          prdata_next;
   logic                addr_ok;
   // event state
   logic                topo_prev_reg;
   logic [NSLAVE:0]     sync_prev_reg;
   logic [NSLAVE-1:0]   topo_diff_reg;
   logic [NSLAVE:0]     sync_list_reg;
   fmer_byte_t          sync_cls_reg;
   logic                sync_i3_reg;
   logic [NSRC-1:0]     pend_reg;
   logic [NSRC-1:0]     pend_set;
   logic [NSRC-1:0]     served;
   logic [1:0][3:0]     pen_reg;
   logic [1:0]          rep_reg;
   logic [1:0]          mon_tick;
   logic [1:0]          mon_bad;
   logic [1:0]          mon_up;
   logic [1:0]          mon_dn;
   logic [NSLAVE:0]     sync_now;
   logic                topo_rise;
   logic                sync_chg;
   // selected record
   logic                sel_v;
   fmer_src_t           sel;
   fmer_word_t          r_code;
   fmer_byte_t          r_cls;
   fmer_byte_t          r_flt;
   fmer_byte_t          r_hno;
   fmer_byte_t          r_prio;
   fmer_word_t          r_i1;
   fmer_word_t          r_i2;
   fmer_word_t          r_i3;
   logic                r_inv;
   fmer_word_t          rx_i3;
   logic [ENTRY_W-1:0]  entry;
   logic [ENTRY_W-1:0]  snap_reg;
   logic [ENTRY_W-1:0]  diag_rd;
   logic [AW-1:0]       wr_ptr_reg;
   logic [CW-1:0]       cnt_reg;
   // event outputs
   logic                evt_valid_reg;
   logic                evt_invoke_reg;
   fmer_word_t          evt_code_reg;
   fmer_byte_t          evt_class_reg;
   fmer_byte_t          evt_fault_reg;
   fmer_byte_t          evt_prio_reg;
   fmer_byte_t          evt_hno_reg;
   fmer_word_t          evt_i1_reg;
   fmer_word_t          evt_i2_reg;
   fmer_word_t          evt_i3_reg;

   wire wr_en = psel_i & penable_i & pready_reg & pwrite_i;

   // apb: zero wait states, answer registered in the setup cycle
   always_comb begin
      addr_ok     = 1'b1;
      prdata_next = '0;
      if (paddr_i == ADDR_CTRL) begin
         prdata_next = ctrl_reg;
      end else if (paddr_i == ADDR_PRIO) begin
         prdata_next = 32'(prio_reg);
      end else if (paddr_i == ADDR_MADDR) begin
         prdata_next = 32'(maddr_reg);
      end else if (paddr_i == ADDR_IOADDR) begin
         prdata_next = 32'(ioaddr_reg);
      end else if (paddr_i == ADDR_SYSID) begin
         prdata_next = 32'(sysid_reg);
      end else if (paddr_i == ADDR_PEN) begin
         prdata_next = 32'({rep_reg, pen_reg[MON_RX], pen_reg[MON_CYC]});
      end else if (paddr_i == ADDR_TOPO) begin
         prdata_next = 32'(topo_diff_reg);
      end else if (paddr_i == ADDR_SYNC) begin
         prdata_next = 32'(sync_list_reg);
      end else if (paddr_i == ADDR_DIDX) begin
         prdata_next = 32'({cnt_reg, wr_ptr_reg, didx_reg});
      end else if (paddr_i == ADDR_DW0) begin
         prdata_next = diag_rd[95:64];
      end else if (paddr_i == ADDR_DW1) begin
         prdata_next = diag_rd[63:32];
      end else if (paddr_i == ADDR_DW2) begin
         prdata_next = diag_rd[31:0];
      end else if (paddr_i == ADDR_SNAP0) begin
         prdata_next = snap_reg[95:64];
      end else if (paddr_i == ADDR_SNAP1) begin
         prdata_next = snap_reg[63:32];
      end else if (paddr_i == ADDR_SNAP2) begin
         prdata_next = snap_reg[31:0];
      end else begin
         addr_ok = 1'b0;
      end
   end

   always_ff @(posedge clk_i) begin
      if (!rstn_i) begin
         pready_reg  <= 1'b0;
         pslverr_reg <= 1'b0;
         prdata_reg  <= '0;
      end else begin
         pready_reg  <= psel_i & ~penable_i;
         pslverr_reg <= psel_i & ~penable_i & ~addr_ok;
         prdata_reg  <= (psel_i & ~penable_i & ~pwrite_i) ? prdata_next : '0;
      end
   end

   // read-only registers simply ignore writes
   always_ff @(posedge clk_i) begin
      if (!rstn_i) begin
         ctrl_reg   <= '0;
         prio_reg   <= '0;
         maddr_reg  <= '0;
         ioaddr_reg <= '0;
         sysid_reg  <= SYSID_BIAS;
         didx_reg   <= '0;
      end else if (wr_en) begin
         if (paddr_i == ADDR_CTRL) begin
            ctrl_reg <= pwdata_i;
         end else if (paddr_i == ADDR_PRIO) begin
            prio_reg <= pwdata_i[15:0];
         end else if (paddr_i == ADDR_MADDR) begin
            maddr_reg <= pwdata_i[15:0];
         end else if (paddr_i == ADDR_IOADDR) begin
            ioaddr_reg <= pwdata_i[15:0];
         end else if (paddr_i == ADDR_SYSID) begin
            sysid_reg <= pwdata_i[7:0];
         end else if (paddr_i == ADDR_DIDX) begin
            didx_reg <= pwdata_i[AW-1:0];
         end
      end
   end

   // topology and clock-sync detection
   assign sync_now  = {master_sync_i, slave_sync_i};
   assign topo_rise = topo_match_i & ~topo_prev_reg;
   assign sync_chg  = sync_now != sync_prev_reg;

   always_ff @(posedge clk_i) begin
      if (!rstn_i) begin
         topo_prev_reg <= 1'b0;
         sync_prev_reg <= '1;
         sync_list_reg <= '1;
         topo_diff_reg <= '0;
         sync_cls_reg  <= CLS_DEPART;
         sync_i3_reg   <= 1'b0;
      end else begin
         topo_prev_reg <= topo_match_i;
         sync_prev_reg <= sync_now;
         if (topo_rise) begin
            topo_diff_reg <= cfg_topo_i ^ act_topo_i;
         end
         if (sync_chg) begin
            sync_list_reg <= sync_now;
            // a slave change wins when master and slave change together
            sync_i3_reg  <= |(sync_now[NSLAVE-1:0] ^
                              sync_prev_reg[NSLAVE-1:0]);
            sync_cls_reg <= (&sync_now) ? CLS_DEPART : CLS_ARRIVE;
         end
      end
   end

   // penalty monitors
   assign mon_tick = {rx_tick_i, cyc_tick_i};
   assign mon_bad  = {rx_timeout_i, cyc_viol_i};

   for (genvar m = 0; m < 2; m++) begin : g_mon
      logic [3:0] pen_next;
      localparam bit GATED = (m == MON_RX);
      always_comb begin
         pen_next = pen_reg[m];
         if (mon_tick[m]) begin
            if (mon_bad[m]) begin
               pen_next = (pen_reg[m] > PEN_MAX - PEN_INC) ? PEN_MAX
                        : 4'(pen_reg[m] + PEN_INC);
            end else if (pen_reg[m] != PEN_MIN) begin
               pen_next = 4'(pen_reg[m] - PEN_DEC);
            end
         end
      end
      // once reported, further violations stay quiet until back at zero
      assign mon_up[m] = (pen_next == PEN_MAX) & ~rep_reg[m];
      assign mon_dn[m] = (pen_next == PEN_MIN) & (pen_reg[m] != PEN_MIN)
                       & (~GATED | rep_reg[m]);
      always_ff @(posedge clk_i) begin
         if (!rstn_i) begin
            pen_reg[m] <= PEN_MIN;
            rep_reg[m] <= 1'b0;
         end else begin
            pen_reg[m] <= pen_next;
            if (mon_up[m]) begin
               rep_reg[m] <= 1'b1;
            end else if (mon_dn[m]) begin
               rep_reg[m] <= 1'b0;
            end
         end
      end
   end

   // pending events; a new event beats the clear of its own flag
   assign pend_set = {mon_dn[MON_RX], mon_up[MON_RX], mon_dn[MON_CYC],
                      mon_up[MON_CYC], sync_chg, topo_rise};

   always_comb begin
      sel_v = 1'b0;
      sel   = SRC_TOPO;
      for (int k = NSRC - 1; k >= 0; k--) begin
         if (pend_reg[k]) begin
            sel_v = 1'b1;
            sel   = fmer_src_t'(k);
         end
      end
   end
   assign served = sel_v ? (NSRC'(1) << sel) : '0;

   always_ff @(posedge clk_i) begin
      if (!rstn_i) begin
         pend_reg <= '0;
      end else begin
         pend_reg <= (pend_reg & ~served) | pend_set;
      end
   end

   // record of the selected event
   assign rx_i3 = WORD_ZERO | (16'(1) << RX_FLAG_BIT)
                | (16'(4'(sysid_reg - SYSID_BIAS)) << RX_ID_LSB);

   always_comb begin
      r_code = CODE_TOPO;
      r_cls  = CLS_DEPART;
      r_flt  = FLT_TOPO;
      r_hno  = HNO_RACK;
      r_prio = prio_reg[7:0];
      r_i1   = WORD_ZERO;
      r_i2   = maddr_reg;
      r_i3   = WORD_ZERO;
      r_inv  = 1'b1;
      case (sel)
         SRC_TOPO: begin
            r_code = CODE_TOPO;
         end
         SRC_SYNC: begin
            r_code = CODE_SYNC;
            r_cls  = sync_cls_reg;
            r_flt  = FLT_SYNC;
            r_hno  = HNO_DIAG;
            r_prio = prio_reg[15:8];
            r_i3   = 16'(sync_i3_reg);
            r_inv  = ctrl_reg[CTRL_DIAG_PRESENT];
         end
         SRC_CYC_NG, SRC_CYC_OK: begin
            r_code = CODE_CYC;
            r_cls  = (sel == SRC_CYC_NG) ? CLS_DEPART : CLS_ARRIVE;
            r_flt  = FLT_CYC;
            r_hno  = HNO_DIAG;
            r_prio = prio_reg[15:8];
            r_i1   = ioaddr_reg;
            r_i2   = WORD_ZERO;
            r_inv  = ctrl_reg[CTRL_DIAG_PRESENT];
         end
         SRC_RX_NG, SRC_RX_OK: begin
            r_code = CODE_RX;
            r_cls  = (sel == SRC_RX_NG) ? CLS_DEPART : CLS_ARRIVE;
            r_flt  = FLT_RX;
            r_i1   = ioaddr_reg;
            r_i2   = WORD_ZERO;
            r_i3   = rx_i3;
         end
         default: begin
            r_inv = 1'b0;
         end
      endcase
   end

   // buffer entry: id, priority, handler, reserved/io flag, three info words
   assign entry = {r_cls, r_flt, r_prio, r_hno, WORD_ZERO,
                   r_i1, r_i2, r_i3};

   always_ff @(posedge clk_i) begin
      if (!rstn_i) begin
         evt_valid_reg  <= 1'b0;
         evt_invoke_reg <= 1'b0;
         evt_code_reg   <= '0;
         evt_class_reg  <= '0;
         evt_fault_reg  <= '0;
         evt_prio_reg   <= '0;
         evt_hno_reg    <= '0;
         evt_i1_reg     <= '0;
         evt_i2_reg     <= '0;
         evt_i3_reg     <= '0;
      end else begin
         evt_valid_reg  <= sel_v;
         evt_invoke_reg <= sel_v & r_inv;
         evt_code_reg   <= r_code;
         evt_class_reg  <= r_cls;
         evt_fault_reg  <= r_flt;
         evt_prio_reg   <= r_prio;
         evt_hno_reg    <= r_hno;
         evt_i1_reg     <= r_i1;
         evt_i2_reg     <= r_i2;
         evt_i3_reg     <= r_i3;
      end
   end

   // diagnostic buffer wraps, oldest entries are overwritten
   always_ff @(posedge clk_i) begin
      if (!rstn_i) begin
         wr_ptr_reg <= '0;
         cnt_reg    <= '0;
         snap_reg   <= '0;
      end else if (sel_v) begin
         wr_ptr_reg <= AW'(wr_ptr_reg + 1'b1);
         if (cnt_reg != CW'(DIAG_DEPTH)) begin
            cnt_reg <= CW'(cnt_reg + 1'b1);
         end
         if (sel == SRC_SYNC) begin
            snap_reg <= entry;
         end
      end
   end

   fmer_diag_mem #(
      .W     (ENTRY_W),
      .DEPTH (DIAG_DEPTH),
      .AW    (AW)
   ) u_mem (
      .clk_i   (clk_i),
      .we_i    (sel_v),
      .waddr_i (wr_ptr_reg),
      .wdata_i (entry),
      .raddr_i (didx_reg),
      .rdata_o (diag_rd)
   );

   assign prdata_o      = prdata_reg;
   assign pready_o      = pready_reg;
   assign pslverr_o     = pslverr_reg;
   assign evt_valid_o   = evt_valid_reg;
   assign evt_invoke_o  = evt_invoke_reg;
   assign evt_code_o    = evt_code_reg;
   assign evt_class_o   = evt_class_reg;
   assign evt_fault_o   = evt_fault_reg;
   assign evt_prio_o    = evt_prio_reg;
   assign evt_handler_o = evt_hno_reg;
   assign evt_info1_o   = evt_i1_reg;
   assign evt_info2_o   = evt_i2_reg;
   assign evt_info3_o   = evt_i3_reg;

   default clocking @(posedge clk_i); endclocking
   default disable iff (!rstn_i);

   sequence topo_rise_s;
      !topo_match_i ##1 topo_match_i;
   endsequence
   sequence topo_evt_s;
      evt_valid_o && evt_code_o == CODE_TOPO;
   endsequence

   topo_event_a: assert property (
      topo_rise_s |-> ##[1:8] topo_evt_s)
      else $error("topology-ok event not raised");
   topo_record_a: assert property (
      topo_evt_s |-> evt_class_o == CLS_DEPART && evt_fault_o == FLT_TOPO
         && evt_info1_o == WORD_ZERO && evt_info3_o == WORD_ZERO
         && evt_handler_o == HNO_RACK)
      else $error("topology-ok record wrong");
   topo_diff_a: assert property (
      topo_rise_s |=> topo_diff_reg == ($past(cfg_topo_i) ^ $past(act_topo_i)))
      else $error("topology difference not stored");
   sync_record_a: assert property (
      evt_valid_o && evt_code_o == CODE_SYNC |-> evt_fault_o == FLT_SYNC
         && (evt_class_o == CLS_ARRIVE || evt_class_o == CLS_DEPART)
         && evt_info1_o == WORD_ZERO)
      else $error("clock-sync record wrong");
   diag_log_a: assert property (
      evt_valid_o |-> wr_ptr_reg == AW'($past(wr_ptr_reg) + 1'b1))
      else $error("event not logged in buffer");
   pen_inc_a: assert property (
      cyc_tick_i && cyc_viol_i && pen_reg[MON_CYC] < 4'h7
         |=> pen_reg[MON_CYC] == $past(pen_reg[MON_CYC]) + 4'h3)
      else $error("cycle penalty not raised by three");
   pen_dec_a: assert property (
      rx_tick_i && !rx_timeout_i && pen_reg[MON_RX] != 4'h0
         |=> pen_reg[MON_RX] == $past(pen_reg[MON_RX]) - 4'h1)
      else $error("receive penalty not lowered by one");
   pen_bound_a: assert property (
      pen_reg[MON_CYC] <= PEN_MAX && pen_reg[MON_RX] <= PEN_MAX)
      else $error("penalty above ceiling");
   cyc_once_a: assert property (
      rep_reg[MON_CYC] |-> !pend_set[SRC_CYC_NG])
      else $error("repeated too-long event");
   rx_ok_gate_a: assert property (
      pend_set[SRC_RX_OK] |-> rep_reg[MON_RX] ##1 !rep_reg[MON_RX])
      else $error("receive-ok without earlier timeout");
   rx_info3_a: assert property (
      evt_valid_o && evt_code_o == CODE_RX |-> evt_info3_o[15]
         && evt_info3_o[14:11] == 4'($past(sysid_reg) - SYSID_BIAS))
      else $error("receive info3 wrong");
endmodule

/* File: sim/fmer_host_model.sv */
/*
 * fmer_host_model: host cpu side, keeps the last event record and a count.
 * Assumes each evt_valid_o pulse lasts one clk_i cycle.
 */
`timescale 1ns/1ps
module fmer_host_model (
   input  wire logic        clk_i,
   input  wire logic        valid_i,
   input  wire logic [99:0] rec_i,
   output logic      [99:0] last_o,
   output int               cnt_o
);
   // no back-pressure exists, so a missed pulse is lost for good
   initial cnt_o = 0;
   always @(posedge clk_i) begin
      if (valid_i === 1'b1) begin
         last_o <= rec_i;
         cnt_o  <= cnt_o + 1;
      end
   end
endmodule

/* File: sim/tb.sv */
/*
 * tb: apb register tasks and event scenarios for fmer_top.
 * Assumes fmer_pkg constants and the host model beside the dut.
 */
`timescale 1ns/1ps
module tb;
   import fmer_pkg::*;
   logic       clk_i = 0, rstn_i = 0, psel_i = 0, penable_i = 0;
   logic       pwrite_i = 0, pready_o, pslverr_o, er;
   fmer_addr_t paddr_i = 8'h00;
   fmer_data_t pwdata_i = 32'h0, prdata_o, rd;
   logic       topo_match_i = 0, master_sync_i = 1, evt_valid_o;
   logic [7:0] cfg_topo_i = 8'h00, act_topo_i = 8'h00, slave_sync_i = 8'hFF;
   logic       cyc_tick_i = 0, cyc_viol_i = 0, rx_tick_i = 0;
   logic       rx_timeout_i = 0, evt_invoke_o;
   fmer_word_t evt_code_o, evt_info1_o, evt_info2_o, evt_info3_o;
   fmer_byte_t evt_class_o, evt_fault_o, evt_prio_o, evt_handler_o;
   logic [99:0] last;
   int         n_evt, seen = 0, n_errors = 0, n_compared = 0;
   always #50 clk_i = ~clk_i;
   fmer_top dut_u (.*);
   fmer_host_model host_u (.clk_i(clk_i), .valid_i(evt_valid_o),
      .rec_i({3'b0, evt_invoke_o, evt_code_o, evt_class_o, evt_fault_o,
      evt_prio_o, evt_handler_o, evt_info1_o, evt_info2_o, evt_info3_o}),
      .last_o(last), .cnt_o(n_evt));
   task automatic report_and_stop;
      if (n_errors == 0 && n_compared > 0) $display("ALL CHECKS OK");
      else $display("CHECKS NOT OK");
      $finish;
   endtask
   task automatic chk(input logic [99:0] g, input logic [99:0] e);
      n_compared++;
      if (g !== e) begin
         n_errors++;
         $display("MISMATCH t=%0t got=%h exp=%h", $time, g, e);
      end
   endtask
   task automatic apb(input logic w, input fmer_addr_t a, input fmer_data_t d);
      int k = 0;
      psel_i   <= 1'b1;
      pwrite_i <= w;
      paddr_i  <= a;
      pwdata_i <= d;
      @(posedge clk_i);
      penable_i <= 1'b1;
      do begin
         @(posedge clk_i);
         k++;
      end while (pready_o !== 1'b1 && k < 50);
      if (k == 50) n_errors++;
      rd = prdata_o;
      er = pslverr_o;
      psel_i    <= 1'b0;
      penable_i <= 1'b0;
      @(posedge clk_i);
   endtask
   task automatic rc(input fmer_addr_t a, input fmer_data_t e);
      apb(1'b0, a, 32'h0);
      chk({er, rd}, {1'b0, e});
   endtask
   // waits bounded for the next event, then checks record and count
   task automatic ev(input logic [99:0] e);
      int k = 0;
      while (n_evt == seen && k < 40) begin
         @(posedge clk_i);
         k++;
      end
      seen++;
      chk(last, e);
      chk(n_evt, seen);
   endtask
   task automatic quiet;
      repeat (8) @(posedge clk_i);
      chk(n_evt, seen);
   endtask
   task automatic tk(input logic rx, input logic bad, input int n);
      repeat (n) begin
         cyc_tick_i   <= !rx;
         rx_tick_i    <= rx;
         cyc_viol_i   <= bad;
         rx_timeout_i <= bad;
         @(posedge clk_i);
         cyc_tick_i <= 1'b0;
         rx_tick_i  <= 1'b0;
         @(posedge clk_i);
      end
   endtask
   initial begin
      #(100 * 3000);
      n_errors++;
      report_and_stop();
   end
   initial begin
      repeat (12) @(posedge clk_i);
      rstn_i <= 1'b1;
      @(posedge clk_i);
      apb(1'b1, ADDR_CTRL, 32'h1);
      apb(1'b1, ADDR_PRIO, 32'h0201);
      apb(1'b1, ADDR_MADDR, 32'h1234);
      apb(1'b1, ADDR_IOADDR, 32'h0ABC);
      apb(1'b1, ADDR_SYSID, 32'h6A);
      cfg_topo_i   <= 8'hA5;
      act_topo_i   <= 8'hA1;
      topo_match_i <= 1'b1;
      ev(100'h1_8003_ED30_0156_0000_1234_0000);
      rc(ADDR_TOPO, 32'h04);
      slave_sync_i <= 8'hFE;
      ev(100'h1_8005_EC50_0252_0000_1234_0001);
      rc(ADDR_SYNC, 32'h1FE);
      slave_sync_i <= 8'hFF;
      ev(100'h1_8005_ED50_0252_0000_1234_0001);
      master_sync_i <= 1'b0;
      ev(100'h1_8005_EC50_0252_0000_1234_0000);
      master_sync_i <= 1'b1;
      ev(100'h1_8005_ED50_0252_0000_1234_0000);
      rc(ADDR_SNAP0, 32'hED500252);
      apb(1'b1, ADDR_DIDX, 32'h0);
      rc(ADDR_DIDX, 32'h550);
      rc(ADDR_DW0, 32'hED300156);
      rc(ADDR_DW1, 32'h0);
      rc(ADDR_DW2, 32'h12340000);
      apb(1'b1, ADDR_CTRL, 32'h0);
      master_sync_i <= 1'b0;
      ev(100'h0_8005_EC50_0252_0000_1234_0000);
      master_sync_i <= 1'b1;
      ev(100'h0_8005_ED50_0252_0000_1234_0000);
      apb(1'b1, ADDR_CTRL, 32'h1);
      tk(1'b0, 1'b1, 1);
      rc(ADDR_PEN, 32'h3);
      tk(1'b0, 1'b1, 2);
      ev(100'h1_8006_ED40_0252_0ABC_0000_0000);
      tk(1'b0, 1'b1, 1);
      quiet();
      rc(ADDR_PEN, 32'h109);
      tk(1'b0, 1'b0, 8);
      rc(ADDR_PEN, 32'h101);
      tk(1'b0, 1'b0, 1);
      ev(100'h1_8006_EC40_0252_0ABC_0000_0000);
      tk(1'b1, 1'b1, 1);
      tk(1'b1, 1'b0, 3);
      quiet();
      tk(1'b1, 1'b1, 2);
      rc(ADDR_PEN, 32'h60);
      tk(1'b1, 1'b0, 1);
      rc(ADDR_PEN, 32'h50);
      tk(1'b1, 1'b1, 2);
      ev(100'h1_8007_ED80_0156_0ABC_0000_B000);
      rc(ADDR_PEN, 32'h290);
      tk(1'b1, 1'b0, 9);
      ev(100'h1_8007_EC80_0156_0ABC_0000_B000);
      apb(1'b0, 8'h3C, 32'h0);
      chk({er, rd}, {1'b1, 32'h0});
      report_and_stop();
   end
endmodule
